//--- hw/gpio_pin_cell.sv
// One pin's driver decode: data and two drive select bits to driver enables
module gpio_pin_cell (
   input wire logic i_data,
   input wire logic i_drive_select_lo,
   input wire logic i_drive_select_hi,
   output logic o_pullup_resistor_switch,
   output logic o_pulldown_driver,
   output logic [1:0] o_sink_class,
   output logic o_high_side_driver,
   output logic o_ttl_threshold
);
   always_comb begin
      o_pullup_resistor_switch = 1'b0;
      o_pulldown_driver = 1'b0;
      o_high_side_driver = 1'b0;
      o_sink_class = {i_drive_select_hi, i_drive_select_lo};
      case ({i_data, i_drive_select_hi, i_drive_select_lo})
         3'b000, 3'b100: begin
            o_sink_class = 2'h0;
         end
         3'b010: begin
            o_pulldown_driver = 1'b1;
         end
         3'b001: begin
            o_pulldown_driver = 1'b1;
         end
         3'b011: begin
            o_pulldown_driver = 1'b1;
         end
         3'b101, 3'b111: begin
            o_high_side_driver = 1'b1;
            o_sink_class = 2'h0;
         end
         3'b110: begin
            o_pullup_resistor_switch = 1'b1;
            o_sink_class = 2'h0;
         end
         default: begin
            o_sink_class = 2'h0;
         end
      endcase
   end

   assign o_ttl_threshold = i_data & ~i_drive_select_hi & ~i_drive_select_lo;
endmodule // gpio_pin_cell

//--- hw/gpio_pkg.sv
// Package: register map, field positions and reset values of the GPIO block
package gpio_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PORT_W = 8;
   // Register byte addresses are four times the printed index
   localparam logic [7:0] IDX_PORT0_DATA = 8'h00;
   localparam logic [7:0] IDX_PORT1_DATA = 8'h01;
   localparam logic [7:0] IDX_AUX_LEVELS = 8'h02;
   localparam logic [7:0] IDX_PORT0_SEL_LO = 8'h0a;
   localparam logic [7:0] IDX_PORT0_SEL_HI = 8'h0b;
   localparam logic [7:0] IDX_PORT1_SEL_LO = 8'h0c;
   localparam logic [7:0] IDX_PORT1_SEL_HI = 8'h0d;
   localparam logic [7:0] IDX_PIN_EVT_STATUS0 = 8'h10;
   localparam logic [7:0] IDX_PIN_EVT_STATUS1 = 8'h11;
   localparam logic [7:0] IDX_PIN_EVT_MASK0 = 8'h12;
   localparam logic [7:0] IDX_PIN_EVT_MASK1 = 8'h13;
   localparam logic [7:0] IDX_AUX_MODE = 8'h14;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Auxiliary port bit positions
   localparam int AUX_BIT_DPLUS = 5;
   localparam int AUX_BIT_DMINUS = 4;
   localparam int AUX_BIT_CRYSTAL = 1;
   localparam int AUX_BIT_REGULATOR = 0;
   // Aux mode register bits
   localparam int AUX_MODE_INT_CLK = 0;
   localparam int AUX_MODE_KBD_SERIAL = 1;
   localparam logic [1:0] AUX_MODE_RESET = 2'h0;
   localparam int SYNC_STAGES = 2;
endpackage

//--- hw/gpio_ports.sv
// GPIO block: two ports, auxiliary input port, Wishbone slave, pin events
//
// Notes on behaviour
// - First port 8 bits; second 2 or 8
// - Writes store drive; reads return pin levels
// - Every general bit can raise an event
// - Pin drive depends only on own bits
// - Reset clears data and select registers
// - Select 00 leaves pin undriven
// - Hi=1 lo=0 data 0: weak sink
// - Hi=0 lo=1 data 0: medium sink
// - Both select, data 0: strong sink
// - Lo=1 data 1: high side only
// - Hi=1 lo=0 data 1: pull-up only
// - TTL only for data 1, select 00
// - Auxiliary port is input only, TTL
// - Aux bits 5,4 are D+ and D-
// - Aux bit 1 is crystal input level when aux mode bit 0 set, else 0
// - Aux bit 0 is regulator pin level when aux mode bit 1 set, else 0
module gpio_ports
   import gpio_pkg::*;
#(
   parameter int SECOND_PORT_W = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [gpio_pkg::ADDR_W-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [gpio_pkg::DATA_W-1:0] i_wb_dat,
   output logic [gpio_pkg::DATA_W-1:0] o_wb_dat,
   output logic o_wb_ack,
   output logic o_irq,
   input wire logic [7:0] i_first_port_pins,
   output logic [7:0] o_first_port_pins,
   output logic [7:0] o_first_port_pins_oe,
   output logic [7:0] o_first_port_pullup,
   output logic [15:0] o_first_port_sink_class,
   output logic [7:0] o_first_port_ttl,
   input wire logic [7:0] i_second_port_pins,
   output logic [7:0] o_second_port_pins,
   output logic [7:0] o_second_port_pins_oe,
   output logic [7:0] o_second_port_pullup,
   output logic [15:0] o_second_port_sink_class,
   output logic [7:0] o_second_port_ttl,
   output logic [15:0] o_pin_levels_to_irq,
   input wire logic i_usb_dplus,
   input wire logic i_usb_dminus,
   input wire logic i_crystal_input_pin,
   input wire logic i_regulator_output_pin,
   output logic o_aux_ttl_threshold
);
   import gpio_pkg::*;

   initial begin
      if (SECOND_PORT_W != 2 && SECOND_PORT_W != 8) begin
         $error("SECOND_PORT_W must be 2 or 8");
      end
   end

   localparam logic [7:0] P1_MASK = (SECOND_PORT_W == 8) ? 8'hff : 8'h03;

   typedef struct packed {
      logic [7:0] p0_data;
      logic [7:0] p1_data;
      logic [7:0] p0_sel_lo;
      logic [7:0] p0_sel_hi;
      logic [7:0] p1_sel_lo;
      logic [7:0] p1_sel_hi;
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] prev;
      logic [3:0] aux_sync1;
      logic [3:0] aux_sync2;
      logic [15:0] evt_status;
      logic [15:0] evt_mask;
      logic [1:0] aux_mode;
      logic ack;
      logic [31:0] rdat;
   } state_t;

   state_t s_q;
   state_t s_d;

   function automatic logic [7:0] reg_index(input logic [7:0] adr);
      reg_index = {2'h0, adr[7:2]};
   endfunction

   function automatic logic [7:0] lane0(input logic [3:0] sel,
                                        input logic [7:0] old,
                                        input logic [7:0] nw);
      lane0 = sel[0] ? nw : old;
   endfunction

   logic req;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic [7:0] aux_value;
   logic [15:0] edge_seen;

   assign req = i_wb_cyc & i_wb_stb & ~s_q.ack;
   assign idx = reg_index(i_wb_adr);
   assign wbyte = i_wb_dat[7:0];

   always_comb begin
      aux_value = 8'h00;
      aux_value[AUX_BIT_DPLUS] = s_q.aux_sync2[3];
      aux_value[AUX_BIT_DMINUS] = s_q.aux_sync2[2];
      aux_value[AUX_BIT_CRYSTAL] = s_q.aux_sync2[1]
         & s_q.aux_mode[AUX_MODE_INT_CLK];
      aux_value[AUX_BIT_REGULATOR] = s_q.aux_sync2[0]
         & s_q.aux_mode[AUX_MODE_KBD_SERIAL];
   end

   // Any level change is an event
   assign edge_seen = (s_q.sync2 ^ s_q.prev) & {P1_MASK, 8'hff};

   always_comb begin
      s_d = s_q;
      s_d.sync1 = {i_second_port_pins & P1_MASK, i_first_port_pins};
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;
      s_d.aux_sync1 = {i_usb_dplus, i_usb_dminus, i_crystal_input_pin,
                       i_regulator_output_pin};
      s_d.aux_sync2 = s_q.aux_sync1;
      s_d.ack = req;
      s_d.rdat = 32'h0000_0000;
      if (req && !i_wb_we) begin
         case (idx)
            IDX_PORT0_DATA: s_d.rdat = {24'h0, s_q.sync2[7:0]};
            IDX_PORT1_DATA: s_d.rdat = {24'h0, s_q.sync2[15:8] & P1_MASK};
            IDX_AUX_LEVELS: s_d.rdat = {24'h0, aux_value};
            IDX_PIN_EVT_STATUS0: s_d.rdat = {24'h0, s_q.evt_status[7:0]};
            IDX_PIN_EVT_STATUS1: s_d.rdat = {24'h0, s_q.evt_status[15:8]};
            IDX_PIN_EVT_MASK0: s_d.rdat = {24'h0, s_q.evt_mask[7:0]};
            IDX_PIN_EVT_MASK1: s_d.rdat = {24'h0, s_q.evt_mask[15:8]};
            IDX_AUX_MODE: s_d.rdat = {30'h0, s_q.aux_mode};
            // Write-only select registers and holes read zero
            default: s_d.rdat = 32'h0000_0000;
         endcase
      end
      if (req && i_wb_we) begin
         case (idx)
            IDX_PORT0_DATA:
               s_d.p0_data = lane0(i_wb_sel, s_q.p0_data, wbyte);
            IDX_PORT1_DATA:
               s_d.p1_data = lane0(i_wb_sel, s_q.p1_data, wbyte & P1_MASK);
            IDX_PORT0_SEL_LO:
               s_d.p0_sel_lo = lane0(i_wb_sel, s_q.p0_sel_lo, wbyte);
            IDX_PORT0_SEL_HI:
               s_d.p0_sel_hi = lane0(i_wb_sel, s_q.p0_sel_hi, wbyte);
            IDX_PORT1_SEL_LO:
               s_d.p1_sel_lo = lane0(i_wb_sel, s_q.p1_sel_lo,
                                     wbyte & P1_MASK);
            IDX_PORT1_SEL_HI:
               s_d.p1_sel_hi = lane0(i_wb_sel, s_q.p1_sel_hi,
                                     wbyte & P1_MASK);
            IDX_PIN_EVT_STATUS0:
               if (i_wb_sel[0]) s_d.evt_status[7:0] = s_q.evt_status[7:0]
                  & ~wbyte;
            IDX_PIN_EVT_STATUS1:
               if (i_wb_sel[0]) s_d.evt_status[15:8] = s_q.evt_status[15:8]
                  & ~wbyte;
            IDX_PIN_EVT_MASK0:
               s_d.evt_mask[7:0] = lane0(i_wb_sel, s_q.evt_mask[7:0], wbyte);
            IDX_PIN_EVT_MASK1:
               s_d.evt_mask[15:8] = lane0(i_wb_sel, s_q.evt_mask[15:8],
                                          wbyte & P1_MASK);
            IDX_AUX_MODE:
               if (i_wb_sel[0]) s_d.aux_mode = wbyte[1:0];
            default: ;
         endcase
      end
      // Set wins over a same-cycle clear
      s_d.evt_status = s_d.evt_status | edge_seen;
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Pin decode, one cell per pin
   logic [15:0] all_data;
   logic [15:0] all_lo;
   logic [15:0] all_hi;
   logic [15:0] pu;
   logic [15:0] pd;
   logic [15:0] hs;
   logic [15:0] ttl;
   logic [31:0] sink;
   assign all_data = {s_q.p1_data, s_q.p0_data};
   assign all_lo = {s_q.p1_sel_lo, s_q.p0_sel_lo};
   assign all_hi = {s_q.p1_sel_hi, s_q.p0_sel_hi};

   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_pin
         gpio_pin_cell u_cell (
            .i_data(all_data[g]),
            .i_drive_select_lo(all_lo[g]),
            .i_drive_select_hi(all_hi[g]),
            .o_pullup_resistor_switch(pu[g]),
            .o_pulldown_driver(pd[g]),
            .o_sink_class(sink[2*g+1:2*g]),
            .o_high_side_driver(hs[g]),
            .o_ttl_threshold(ttl[g])
         );
      end
   endgenerate

   logic [15:0] impl;
   assign impl = {P1_MASK, 8'hff};
   // Output drives high for the high side driver, low for any sink
   assign o_first_port_pins = hs[7:0];
   assign o_first_port_pins_oe = (hs[7:0] | pd[7:0]);
   assign o_first_port_pullup = pu[7:0];
   assign o_first_port_sink_class = sink[15:0];
   assign o_first_port_ttl = ttl[7:0];
   assign o_second_port_pins = hs[15:8] & impl[15:8];
   assign o_second_port_pins_oe = (hs[15:8] | pd[15:8]) & impl[15:8];
   assign o_second_port_pullup = pu[15:8] & impl[15:8];
   assign o_second_port_sink_class = sink[31:16];
   assign o_second_port_ttl = ttl[15:8] & impl[15:8];
   // Pin levels forwarded to interrupt logic
   assign o_pin_levels_to_irq = s_q.sync2;
   assign o_aux_ttl_threshold = 1'b1;
   assign o_irq = |(s_q.evt_status & s_q.evt_mask);
   assign o_wb_ack = s_q.ack;
   assign o_wb_dat = s_q.rdat;

   property p_ack_one;
      @(posedge i_ref_clk) disable iff (i_reset)
         (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack not single");

   property p_undriven;
      @(posedge i_ref_clk) disable iff (i_reset)
         (s_q.p0_sel_lo[0] == 1'b0 && s_q.p0_sel_hi[0] == 1'b0)
         |-> !o_first_port_pins_oe[0] && !o_first_port_pullup[0];
   endproperty
   a_undriven: assert property (p_undriven) else $error("pin driven");

   property p_sink;
      @(posedge i_ref_clk) disable iff (i_reset)
         (!s_q.p0_data[1] && (s_q.p0_sel_lo[1] || s_q.p0_sel_hi[1]))
         |-> o_first_port_pins_oe[1] && !o_first_port_pins[1]
         && o_first_port_sink_class[3:2] == {s_q.p0_sel_hi[1],
                                            s_q.p0_sel_lo[1]};
   endproperty
   a_sink: assert property (p_sink) else $error("sink wrong");

   property p_high;
      @(posedge i_ref_clk) disable iff (i_reset)
         (s_q.p0_data[2] && s_q.p0_sel_lo[2]) |-> o_first_port_pins[2]
         && o_first_port_pins_oe[2] && !o_first_port_pullup[2];
   endproperty
   a_high: assert property (p_high) else $error("high drive wrong");

   property p_pullup;
      @(posedge i_ref_clk) disable iff (i_reset)
         (s_q.p0_data[3] && s_q.p0_sel_hi[3] && !s_q.p0_sel_lo[3])
         |-> o_first_port_pullup[3] && !o_first_port_pins_oe[3];
   endproperty
   a_pullup: assert property (p_pullup) else $error("pullup wrong");

   property p_ttl;
      @(posedge i_ref_clk) disable iff (i_reset)
         o_first_port_ttl[4] == (s_q.p0_data[4] && !s_q.p0_sel_lo[4]
                                 && !s_q.p0_sel_hi[4]);
   endproperty
   a_ttl: assert property (p_ttl) else $error("threshold wrong");

   property p_read_pins;
      @(posedge i_ref_clk) disable iff (i_reset)
         (req && !i_wb_we && idx == IDX_PORT0_DATA)
         |=> o_wb_dat[7:0] == $past(s_q.sync2[7:0]);
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("read wrong");

   property p_evt_set;
      @(posedge i_ref_clk) disable iff (i_reset)
         (edge_seen[0]) |=> s_q.evt_status[0];
   endproperty
   a_evt_set: assert property (p_evt_set) else $error("event lost");

   property p_p1_zero;
      @(posedge i_ref_clk) disable iff (i_reset)
         ((s_q.p1_data | s_q.p1_sel_lo | s_q.p1_sel_hi) & ~P1_MASK) == 8'h00;
   endproperty
   a_p1_zero: assert property (p_p1_zero) else $error("missing bit set");

   property p_aux_reserved;
      @(posedge i_ref_clk) disable iff (i_reset)
         (req && !i_wb_we && idx == IDX_AUX_LEVELS)
         |=> o_wb_dat[7:6] == 2'h0 && o_wb_dat[3:2] == 2'h0;
   endproperty
   a_aux_reserved: assert property (p_aux_reserved) else $error("aux rsv");
endmodule // gpio_ports

//--- test/board_pins.sv
// Board side of one port: resolves each pin from device and board drivers
module board_pins (
   input wire logic i_ref_clk,
   input wire logic [7:0] i_oe,
   input wire logic [7:0] i_drive,
   input wire logic [7:0] i_pullup,
   input wire logic [7:0] i_ext_en,
   input wire logic [7:0] i_ext_val,
   output logic [7:0] o_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // Floating pins wander so a stale value never passes
   logic [7:0] float_q = 8'h55;
   always_ff @(posedge i_ref_clk) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         o_level[k] = i_oe[k] ? i_drive[k] : i_ext_en[k] ? i_ext_val[k] :
            i_pullup[k] ? 1'b1 : float_q[k];
      end
   end
endmodule // board_pins

//--- test/test_gpio_ports_with_aux_input.sv
// Self-checking bench for the GPIO block with auxiliary input port
module test_gpio_ports_with_aux_input;
   timeunit 1ns;
   timeprecision 1ns;
   import gpio_pkg::*;
   localparam int SP_W = 2;
   localparam logic [7:0] P1M = (SP_W == 8) ? 8'hff : 8'h03;
   logic clk, rst, cyc, stb, we, ack, irq, aux_ttl, dp, dm, xt, rg;
   logic [7:0] adr, ee0, ee1, ev0, ev1, lv0, lv1;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, r;
   logic [7:0] pd0, oe0, pu0, tt0, pd1, oe1, pu1, tt1;
   logic [15:0] sc0, sc1, lvirq;
   logic [31:0] exp_q[$];
   int mismatches = 0, n_compared = 0, cycles = 0, i;
   int seed = 32'h02ce671f;

   gpio_ports #(.SECOND_PORT_W(SP_W)) i_gpio_ports (.i_ref_clk(clk),
      .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .o_irq(irq), .i_first_port_pins(lv0),
      .o_first_port_pins(pd0), .o_first_port_pins_oe(oe0),
      .o_first_port_pullup(pu0), .o_first_port_sink_class(sc0),
      .o_first_port_ttl(tt0), .i_second_port_pins(lv1),
      .o_second_port_pins(pd1), .o_second_port_pins_oe(oe1),
      .o_second_port_pullup(pu1), .o_second_port_sink_class(sc1),
      .o_second_port_ttl(tt1), .o_pin_levels_to_irq(lvirq),
      .i_usb_dplus(dp), .i_usb_dminus(dm), .i_crystal_input_pin(xt),
      .i_regulator_output_pin(rg), .o_aux_ttl_threshold(aux_ttl));
   board_pins b0 (.i_ref_clk(clk), .i_oe(oe0), .i_drive(pd0),
      .i_pullup(pu0), .i_ext_en(ee0), .i_ext_val(ev0), .o_level(lv0));
   board_pins b1 (.i_ref_clk(clk), .i_oe(oe1), .i_drive(pd1),
      .i_pullup(pu1), .i_ext_en(ee1), .i_ext_val(ev1), .o_level(lv1));

   task automatic check(input string what, input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // One classic cycle; read expectations go to the queue
   task automatic wb(input logic w, input logic [7:0] idx, d, e);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx[5:0], 2'b00};
      wdat <= {24'h0, d};
      if (!w) exp_q.push_back({24'h0, e});
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, e);
      wb(1'b0, idx, 8'h00, e);
   endtask

   // Expected drive state of one port from its three bytes
   task automatic chk(input logic p, input logic [7:0] d, hi, lo);
      logic [7:0] m, sk;
      logic [15:0] sc;
      m = p ? P1M : 8'hff;
      d = d & m;
      hi = hi & m;
      lo = lo & m;
      sk = ~d & (hi | lo);
      for (int k = 0; k < 8; k++) sc[2*k+:2] = sk[k] ? {hi[k], lo[k]} : 2'b0;
      check("oe", p ? oe1 : oe0, sk | (lo & d));
      check("drive", p ? pd1 : pd0, lo & d);
      check("pullup", p ? pu1 : pu0, hi & ~lo & d);
      check("sink", p ? sc1 : sc0, sc);
      check("ttl", p ? tt1 : tt0, d & ~hi & ~lo);
   endtask

   task automatic cfg(input logic p, input logic [7:0] d, hi, lo);
      wb(1'b1, {7'h0, p}, d, 8'h0);
      wb(1'b1, 8'(IDX_PORT0_SEL_LO + 2 * p), lo, 8'h0);
      wb(1'b1, 8'(IDX_PORT0_SEL_HI + 2 * p), hi, 8'h0);
      @(negedge clk);
      chk(p, d, hi, lo);
   endtask

   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
         check("read", rdat, exp_q.pop_front());
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict;
      end
   end

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      {rst, cyc, stb, we, adr, wdat, dp, dm, xt, rg} = {1'b1, 49'h0};
      sel = 4'h1;
      {ee0, ee1, ev0, ev1} = {16'hffff, 16'ha43c};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk(1'b0, 8'h0, 8'h0, 8'h0);
      chk(1'b1, 8'h0, 8'h0, 8'h0);
      rd(IDX_PORT0_DATA, ev0);
      rd(IDX_PORT1_DATA, ev1 & P1M);
      for (i = 0; i < 4; i++) begin
         wb(1'b1, 8'(IDX_PORT0_SEL_LO + i), 8'hff, 8'h0);
         rd(8'(IDX_PORT0_SEL_LO + i), 8'h00);
      end
      wb(1'b1, 8'h20, 8'hff, 8'h0);
      rd(8'h20, 8'h00);
      cfg(1'b0, 8'hf0, 8'hcc, 8'haa);
      cfg(1'b1, 8'hf0, 8'hcc, 8'haa);
      repeat (6) begin
         r = $random(seed);
         cfg(1'b0, r[7:0], r[15:8], r[23:16]);
         cfg(1'b1, r[31:24], r[7:0], r[15:8]);
      end
      // Stored drive differs from what the board shows
      cfg(1'b0, 8'h5b, 8'h00, 8'h00);
      repeat (5) @(posedge clk);
      rd(IDX_PORT0_DATA, ev0);
      ee0 <= 8'hfe;
      cfg(1'b0, 8'h01, 8'h01, 8'h00);
      repeat (5) @(posedge clk);
      rd(IDX_PORT0_DATA, ev0 | 8'h01);
      // Open drain: data and hi held low, lo toggled
      cfg(1'b0, 8'h00, 8'h00, 8'h01);
      repeat (5) @(posedge clk);
      rd(IDX_PORT0_DATA, ev0);
      ee0 <= 8'hff;
      {dp, dm, xt, rg} <= 4'b1011;
      for (i = 0; i < 4; i++) begin
         wb(1'b1, IDX_AUX_MODE, 8'(i), 8'h0);
         repeat (4) @(posedge clk);
         rd(IDX_AUX_LEVELS, 8'h20 | {6'h0, i[0], i[1]});
      end
      {dp, dm} <= 2'b01;
      repeat (4) @(posedge clk);
      rd(IDX_AUX_LEVELS, 8'h13);
      check("aux_ttl", {31'h0, aux_ttl}, 32'h1);
      wb(1'b1, IDX_PIN_EVT_STATUS0, 8'hff, 8'h0);
      wb(1'b1, IDX_PIN_EVT_STATUS1, 8'hff, 8'h0);
      ev0 <= 8'hac;
      repeat (6) @(posedge clk);
      rd(IDX_PIN_EVT_STATUS0, 8'h08);
      @(negedge clk);
      check("irq", {31'h0, irq}, 32'h0);
      check("levels", {24'h0, lvirq[7:0]}, 32'hac);
      wb(1'b1, IDX_PIN_EVT_MASK0, 8'h08, 8'h0);
      @(negedge clk);
      check("irq", {31'h0, irq}, 32'h1);
      wb(1'b1, IDX_PIN_EVT_STATUS0, 8'h08, 8'h0);
      @(negedge clk);
      check("irq", {31'h0, irq}, 32'h0);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(1'b0, 8'h0, 8'h0, 8'h0);
      chk(1'b1, 8'h0, 8'h0, 8'h0);
      check("irq", {31'h0, irq}, 32'h0);
      give_verdict;
   end
endmodule // test_gpio_ports_with_aux_input
